/* common/rtc_ctrl_pkg.sv */
package rtc_ctrl_pkg;
  // Bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 4;

  // Control register addresses
  localparam logic [3:0] ADDR_HOLD  = 4'hd;
  localparam logic [3:0] ADDR_PULSE = 4'he;
  localparam logic [3:0] ADDR_MODE  = 4'hf;

  // Hold and interrupt control fields
  localparam int BIT_HOLD  = 0;
  localparam int BIT_BUSY  = 1;
  localparam int BIT_FLAG  = 2;
  localparam int BIT_ROUND = 3;
  // Pulse output control fields
  localparam int BIT_MASK  = 0;
  localparam int BIT_INT   = 1;
  localparam int BIT_TSEL  = 2;
  // Run mode control fields
  localparam int BIT_DCLR  = 0;
  localparam int BIT_STOP  = 1;
  localparam int BIT_H24   = 2;
  localparam int BIT_TEST  = 3;

  // Values after reset
  localparam logic [3:0]  RST_PULSE_CTL = 4'h1;
  localparam logic [3:0]  RST_MODE_CTL  = 4'h0;
  localparam logic [13:0] PIN_SYNC_RST  = 14'h0e00;

  // Register select codes
  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_HOLD  = 2'b01,
    SEL_MODE  = 2'b11,
    SEL_PULSE = 2'b10
  } ctrl_sel_t;

  // Period select codes
  typedef enum logic [1:0] {
    PER_64HZ = 2'b00,
    PER_SEC  = 2'b01,
    PER_MIN  = 2'b10,
    PER_HOUR = 2'b11
  } period_t;

  // Time base divider
  localparam int XT_DIV_W   = 15;
  localparam int STOP_STAGE = 2;
  localparam int SUB64_W    = 9;

  // Timing
  localparam longint CLK_PERIOD_PS  = 8000;
  localparam longint ROUND_TIME_NS  = 125000;
  localparam longint PULSE_TIME_PS  = 64'd7812500000;
  localparam int ROUND_CYCLES_DEF = int'(ROUND_TIME_NS * 1000 / CLK_PERIOD_PS);
  localparam int PULSE_CYCLES_DEF = int'(PULSE_TIME_PS / CLK_PERIOD_PS);
endpackage

/* common/rtc_evt_if.sv */
interface rtc_evt_if;
  logic       xt_tick;
  logic       div_clear;
  logic       count_stop;
  logic       tick_64hz;
  logic       sec_carry;
  logic       sec_step;
  logic       min_carry;
  logic       hour_carry;
  logic       mask;
  logic       int_mode;
  logic       flag_clear;
  logic       pulse_low;
  logic [1:0] period_sel;

  modport tb_mp (input xt_tick, div_clear, count_stop, output tick_64hz, sec_carry);
  modport pg_mp (input tick_64hz, sec_step, min_carry, hour_carry, mask, int_mode,
                 period_sel, count_stop, flag_clear, output pulse_low);
  modport top_mp (output xt_tick, div_clear, count_stop, sec_step, min_carry, hour_carry,
                  mask, int_mode, period_sel, flag_clear,
                  input tick_64hz, sec_carry, pulse_low);
endinterface

/* rtl/rtc_time_base.sv */
module rtc_time_base (
  input wire logic  clk_in,   // System clock
  input wire logic  rst_n_in, // Asynchronous reset, active low
  rtc_evt_if.tb_mp  evt       // Ticks and divider control
);
  import rtc_ctrl_pkg::*;

  logic [XT_DIV_W-1:0] div_reg;
  logic [XT_DIV_W-1:0] div_next;

  // Stages below the 4096 Hz stage run unless the divider is cleared; carries above are gated
  wire low_wrap = evt.xt_tick & (&div_reg[STOP_STAGE-1:0]);
  wire up_step  = low_wrap & ~evt.count_stop & ~evt.div_clear;
  wire [STOP_STAGE-1:0]          lo_next = div_reg[STOP_STAGE-1:0] + STOP_STAGE'(evt.xt_tick);
  wire [XT_DIV_W-STOP_STAGE-1:0] up_next = div_reg[XT_DIV_W-1:STOP_STAGE]
                                           + (XT_DIV_W-STOP_STAGE)'(up_step);
  assign div_next = evt.div_clear ? '0 : {up_next, lo_next};

  // Carries into the 1/64 s stage and into the seconds digit
  assign evt.tick_64hz = up_step & (&div_reg[SUB64_W-1:STOP_STAGE]);
  assign evt.sec_carry = up_step & (&div_reg[XT_DIV_W-1:STOP_STAGE]);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) div_reg <= '0;
    else           div_reg <= div_next;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_clear_holds;
    evt.div_clear |=> div_reg == '0;
  endproperty
  a_clear_holds: assert property (p_clear_holds) else $error("divider not cleared");

  property p_stop_blocks;
    evt.count_stop && !evt.div_clear
      |=> div_reg[XT_DIV_W-1:STOP_STAGE] == $past(div_reg[XT_DIV_W-1:STOP_STAGE]);
  endproperty
  a_stop_blocks: assert property (p_stop_blocks) else $error("upper divider moved in stop");

  property p_cov_sec;
    evt.sec_carry;
  endproperty
  c_cov_sec: cover property (p_cov_sec);
endmodule // rtc_time_base

/* rtl/rtc_pulse_gen.sv */
module rtc_pulse_gen #(
  parameter int PULSE_CYCLES = rtc_ctrl_pkg::PULSE_CYCLES_DEF // Standard pulse width
) (
  input wire logic  clk_in,   // System clock
  input wire logic  rst_n_in, // Asynchronous reset, active low
  rtc_evt_if.pg_mp  evt       // Events and pulse control
);
  import rtc_ctrl_pkg::*;

  localparam int TW = $clog2(PULSE_CYCLES + 1);
  if (PULSE_CYCLES < 2) begin : g_bad_width
    $error("PULSE_CYCLES must be at least 2");
  end

  logic          pend_reg;
  logic [TW-1:0] tmr_reg;

  // Period event, taken at the carry into the selected digit
  logic per_event;
  always_comb begin
    case (period_t'(evt.period_sel))
      PER_64HZ: per_event = evt.tick_64hz;
      PER_SEC:  per_event = evt.sec_step;
      PER_MIN:  per_event = evt.min_carry;
      PER_HOUR: per_event = evt.hour_carry;
      default:  per_event = 1'b0;
    endcase
  end

  // Standard mode output is frozen while counting is stopped
  wire frozen   = evt.count_stop & ~evt.int_mode;
  // Event taken when idle or with a clear in the same cycle; the clear loses to it
  wire take     = per_event & ~evt.mask & (~pend_reg | evt.flag_clear) & ~frozen;
  wire std_run  = pend_reg & ~evt.int_mode & ~evt.count_stop;
  wire auto_end = std_run & (tmr_reg == TW'(1));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)          pend_reg <= 1'b0;
    else if (evt.mask)      pend_reg <= 1'b0;
    else if (take)          pend_reg <= 1'b1;
    else if (evt.flag_clear) pend_reg <= 1'b0;
    else if (auto_end)      pend_reg <= 1'b0;
  end

  // Fixed low width, whatever the period
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)                  tmr_reg <= '0;
    else if (take)                  tmr_reg <= TW'(PULSE_CYCLES);
    else if (std_run && tmr_reg != '0) tmr_reg <= tmr_reg - TW'(1);
  end

  assign evt.pulse_low = pend_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_event_sets;
    per_event && !evt.mask && !pend_reg && !frozen |=> pend_reg;
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not pull low");

  property p_int_stays;
    evt.int_mode && pend_reg && !evt.flag_clear && !evt.mask |=> pend_reg;
  endproperty
  a_int_stays: assert property (p_int_stays) else $error("interrupt low ended early");

  property p_ignore_new;
    std_run && per_event && !evt.flag_clear && !evt.mask && tmr_reg > TW'(1)
      |=> tmr_reg == $past(tmr_reg) - TW'(1);
  endproperty
  a_ignore_new: assert property (p_ignore_new) else $error("pending event restarted");

  property p_mask_open;
    evt.mask |=> !evt.pulse_low;
  endproperty
  a_mask_open: assert property (p_mask_open) else $error("output low while masked");

  property p_width_load;
    $rose(pend_reg) |-> tmr_reg == TW'(PULSE_CYCLES);
  endproperty
  a_width_load: assert property (p_width_load) else $error("pulse width not loaded");

  property p_stop_frozen;
    !evt.int_mode && evt.count_stop && !evt.mask && !evt.flag_clear
      |=> $stable(pend_reg);
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("output moved in stop");

  property p_cov_auto;
    auto_end && !evt.flag_clear;
  endproperty
  c_cov_auto: cover property (p_cov_auto);

  property p_cov_hour;
    evt.period_sel == PER_HOUR && take;
  endproperty
  c_cov_hour: cover property (p_cov_hour);
endmodule // rtc_pulse_gen

/* rtl/rtc_ctrl_top.sv */
module rtc_ctrl_top #(
  parameter int PULSE_CYCLES = rtc_ctrl_pkg::PULSE_CYCLES_DEF, // Standard pulse width
  parameter int ROUND_CYCLES = rtc_ctrl_pkg::ROUND_CYCLES_DEF  // Round busy time
) (
  input  wire logic                             SYS_CLK_IN,            // 125 MHz clock
  input  wire logic                             RST_N_IN,              // Async reset
  input  wire logic                             XT_CLK_IN,             // 32.768 kHz base
  input  wire logic [rtc_ctrl_pkg::ADDR_W-1:0]  ADDR_IN,               // Register address
  input  wire logic                             ALE_IN,                // Address latch
  input  wire logic                             RD_N_IN,               // Read strobe
  input  wire logic                             WR_N_IN,               // Write strobe
  input  wire logic                             BUS_SELECT_N_IN,       // Bus select
  input  wire logic                             POWER_GOOD_SELECT_IN,  // Power good select
  input  wire logic [rtc_ctrl_pkg::DATA_W-1:0]  DATA_IN,               // Data pins in
  output wire logic [rtc_ctrl_pkg::DATA_W-1:0]  DATA_OUT,              // Data pins out
  output wire logic                             DATA_OE_N_OUT,         // Data drive enable
  input  wire logic                             MIN_CARRY_IN,          // Minute carry
  input  wire logic                             HOUR_CARRY_IN,         // Hour carry
  output wire logic                             SEC_STEP_OUT,          // Seconds step
  output wire logic                             ROUND_REQ_OUT,         // Start of rounding
  output wire logic                             HOUR_24_MODE_OUT,      // 24-hour select
  output wire logic                             TIMING_PULSE_OUT,      // Open drain level
  output wire logic                             TIMING_PULSE_OE_N_OUT  // Open drain enable
);
  import rtc_ctrl_pkg::*;

  localparam int RCW = $clog2(ROUND_CYCLES + 1);
  localparam int SW  = 14;
  if (ROUND_CYCLES < 2) begin : g_bad_round
    $error("ROUND_CYCLES must be at least 2");
  end

  // Register select decode, shared by the read and write paths
  function automatic ctrl_sel_t ctrl_sel(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_HOLD:  return SEL_HOLD;
      ADDR_PULSE: return SEL_PULSE;
      ADDR_MODE:  return SEL_MODE;
      default:    return SEL_NONE;
    endcase
  endfunction

  // Pin synchroniser, two stages
  logic [SW-1:0] pin_s1_reg;
  logic [SW-1:0] pin_s2_reg;
  wire  [SW-1:0] pin_raw = {XT_CLK_IN, ALE_IN, RD_N_IN, WR_N_IN, BUS_SELECT_N_IN,
                            POWER_GOOD_SELECT_IN, ADDR_IN, DATA_IN};

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_s1_reg <= PIN_SYNC_RST;
      pin_s2_reg <= PIN_SYNC_RST;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Synchronised pin names
  wire              xt_s   = pin_s2_reg[13];
  wire              ale_s  = pin_s2_reg[12];
  wire              rd_n_s = pin_s2_reg[11];
  wire              wr_n_s = pin_s2_reg[10];
  wire              bsel_n = pin_s2_reg[9];
  wire              pgood  = pin_s2_reg[8];
  wire [ADDR_W-1:0] addr_s = pin_s2_reg[7:4];
  wire [DATA_W-1:0] data_s = pin_s2_reg[3:0];

  // Edge history for the time base and write strobe
  logic xt_q_reg;
  logic wr_n_q_reg;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      xt_q_reg   <= 1'b0;
      wr_n_q_reg <= 1'b1;
    end else begin
      xt_q_reg   <= xt_s;
      wr_n_q_reg <= wr_n_s;
    end
  end

  // Address latch, transparent while the latch enable is high
  logic [ADDR_W-1:0] addr_lat_reg;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)            addr_lat_reg <= '0;
    else if (ale_s && !bsel_n) addr_lat_reg <= addr_s;
  end

  // Bus access decode
  wire [ADDR_W-1:0] addr_eff = ale_s ? addr_s : addr_lat_reg;
  wire              chip_sel = pgood & ~bsel_n;
  ctrl_sel_t        acc_sel;
  assign acc_sel = ctrl_sel(addr_eff);
  wire wr_strobe = chip_sel & wr_n_s & ~wr_n_q_reg;
  wire rd_act    = chip_sel & ~rd_n_s & wr_n_s;
  wire wr_hold   = wr_strobe && acc_sel == SEL_HOLD;
  wire wr_pulse  = wr_strobe && acc_sel == SEL_PULSE;
  wire wr_mode   = wr_strobe && acc_sel == SEL_MODE;

  // Control register state
  logic           hold_reg;
  logic           round_reg;
  logic [RCW-1:0] round_cnt_reg;
  logic           round_req_reg;
  logic [3:0]     pulse_ctl_reg;
  logic [3:0]     mode_ctl_reg;
  logic           sec_pend_reg;
  logic           sec_step_reg;
  logic [3:0]     rd_data_reg;
  logic           rd_oe_n_reg;

  // Freeze bit, dropped while power is not good
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)    hold_reg <= 1'b0;
    else if (!pgood)  hold_reg <= 1'b0;
    else if (wr_hold) hold_reg <= data_s[BIT_HOLD];
  end

  // Half-minute round, self clearing after a fixed time
  wire round_start = wr_hold & data_s[BIT_ROUND] & ~round_reg;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      round_reg     <= 1'b0;
      round_cnt_reg <= '0;
    end else if (round_start) begin
      round_reg     <= 1'b1;
      round_cnt_reg <= RCW'(ROUND_CYCLES);
    end else if (round_reg) begin
      round_reg     <= round_cnt_reg != RCW'(1);
      round_cnt_reg <= round_cnt_reg - RCW'(1);
    end
  end

  // Request to the counters; resulting carries return as minute carries
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) round_req_reg <= 1'b0;
    else           round_req_reg <= round_start;
  end

  // Pulse output and run mode registers
  wire [3:0] mode_ctl_wr = data_s & ~{3'b000, bsel_n};
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pulse_ctl_reg <= RST_PULSE_CTL;
      mode_ctl_reg  <= RST_MODE_CTL;
    end else begin
      if (wr_pulse) pulse_ctl_reg <= data_s;
      if (wr_mode)  mode_ctl_reg  <= mode_ctl_wr;
      else if (bsel_n) mode_ctl_reg[BIT_DCLR] <= 1'b0;
    end
  end

  // Seconds step: blocked while frozen, a held carry is released later
  wire sec_carry;
  wire sec_step_next = ~hold_reg & (sec_carry | sec_pend_reg);
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sec_pend_reg <= 1'b0;
      sec_step_reg <= 1'b0;
    end else begin
      if (hold_reg && sec_carry) sec_pend_reg <= 1'b1;
      else if (!hold_reg)        sec_pend_reg <= 1'b0;
      sec_step_reg <= sec_step_next;
    end
  end

  // Busy while rounding or while the seconds digit is being stepped
  wire busy = round_reg | sec_step_reg;

  // Read data selection
  wire pulse_low;
  logic [3:0] rd_mux;
  always_comb begin
    case (acc_sel)
      SEL_HOLD:  rd_mux = {round_reg, pulse_low, busy, hold_reg};
      SEL_PULSE: rd_mux = pulse_ctl_reg;
      SEL_MODE:  rd_mux = mode_ctl_reg;
      default:   rd_mux = 4'h0;
    endcase
  end

  // Read data and drive enable come from flip-flops
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_data_reg <= 4'h0;
      rd_oe_n_reg <= 1'b1;
    end else begin
      rd_data_reg <= rd_mux;
      rd_oe_n_reg <= ~(rd_act && acc_sel != SEL_NONE);
    end
  end

  // Time base and pulse generator
  rtc_evt_if evt ();
  assign evt.xt_tick    = xt_s & ~xt_q_reg;
  assign evt.div_clear  = mode_ctl_reg[BIT_DCLR];
  assign evt.count_stop = mode_ctl_reg[BIT_STOP];
  assign evt.sec_step   = sec_step_reg;
  assign evt.min_carry  = MIN_CARRY_IN;
  assign evt.hour_carry = HOUR_CARRY_IN;
  assign evt.mask       = pulse_ctl_reg[BIT_MASK];
  assign evt.int_mode   = pulse_ctl_reg[BIT_INT];
  assign evt.period_sel = pulse_ctl_reg[BIT_TSEL+1:BIT_TSEL];
  assign evt.flag_clear = wr_hold & ~data_s[BIT_FLAG];
  assign sec_carry      = evt.sec_carry;
  assign pulse_low      = evt.pulse_low;

  rtc_time_base u_time_base (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .evt      (evt.tb_mp)
  );

  rtc_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulse_gen (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .evt      (evt.pg_mp)
  );

  // Outputs
  assign DATA_OUT              = rd_data_reg;
  assign DATA_OE_N_OUT         = rd_oe_n_reg;
  assign SEC_STEP_OUT          = sec_step_reg;
  assign ROUND_REQ_OUT         = round_req_reg;
  assign HOUR_24_MODE_OUT      = mode_ctl_reg[BIT_H24];
  assign TIMING_PULSE_OUT      = 1'b0;
  assign TIMING_PULSE_OE_N_OUT = ~pulse_low;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  property p_hold_blocks;
    hold_reg && sec_carry |=> !sec_step_reg;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("step passed while frozen");

  property p_late_step;
    hold_reg && sec_carry ##1 !hold_reg |=> sec_step_reg;
  endproperty
  a_late_step: assert property (p_late_step) else $error("held carry lost");

  property p_pgood_drop;
    !pgood |=> !hold_reg;
  endproperty
  a_pgood_drop: assert property (p_pgood_drop) else $error("freeze kept without power");

  property p_flag_read;
    rd_act && acc_sel == SEL_HOLD |=> rd_data_reg[BIT_FLAG] == $past(pulse_low)
                                      && !rd_oe_n_reg;
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag not inverse of output");

  property p_round_busy;
    round_start |=> round_reg[*8] ##0 busy;
  endproperty
  a_round_busy: assert property (p_round_busy) else $error("round bit cleared early");

  // Age of the current round, kept apart from the down counter it checks
  logic [RCW-1:0] round_age_reg;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)        round_age_reg <= '0;
    else if (round_start) round_age_reg <= '0;
    else if (round_reg)   round_age_reg <= round_age_reg + RCW'(1);
  end

  property p_round_length;
    round_reg |=> round_reg == (round_age_reg != RCW'(ROUND_CYCLES));
  endproperty
  a_round_length: assert property (p_round_length) else $error("round bit length wrong");

  property p_round_req;
    round_start |=> ROUND_REQ_OUT ##1 !ROUND_REQ_OUT;
  endproperty
  a_round_req: assert property (p_round_req) else $error("round request not a pulse");

  property p_deselect_clear;
    bsel_n |=> !mode_ctl_reg[BIT_DCLR];
  endproperty
  a_deselect_clear: assert property (p_deselect_clear) else $error("divider clear kept");

  property p_cov_held;
    hold_reg && sec_carry;
  endproperty
  c_cov_held: cover property (p_cov_held);

  property p_cov_round;
    $fell(round_reg);
  endproperty
  c_cov_round: cover property (p_cov_round);
endmodule // rtc_ctrl_top

/* verification/rtc_host_model.sv */
module rtc_host_model (
  input  wire logic       clk_in,   // System clock
  input  wire logic [3:0] bus_in,   // Resolved data pins
  input  wire logic       oe_n_in,  // Block data drive enable
  output logic      [3:0] addr_out, // Address pins
  output logic            rd_n_out, // Read strobe
  output logic            wr_n_out, // Write strobe
  output logic      [3:0] dat_out,  // Host data
  output logic            drv_out   // High while host drives data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus with strobes released
  initial begin
    addr_out = 4'h0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    dat_out  = 4'h0;
    drv_out  = 1'b0;
  end

  // Write: strobe low two clocks, data held past the rising strobe edge
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk_in) #1;
    addr_out = a;
    dat_out  = d;
    drv_out  = 1'b1;
    wr_n_out = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 wr_n_out = 1'b1;
    repeat (2) @(posedge clk_in);
    #1 drv_out = 1'b0;
    repeat (2) @(posedge clk_in);
  endtask

  // Read: sample once the answer stands, then release and let it drop
  task automatic rd(input logic [3:0] a, output logic [3:0] d, output logic oe_n);
    @(posedge clk_in) #1;
    addr_out = a;
    rd_n_out = 1'b0;
    repeat (4) @(posedge clk_in);
    d    = bus_in;
    oe_n = oe_n_in;
    #1 rd_n_out = 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // rtc_host_model

/* verification/rtc_control_and_timing_pulse_tb_top.sv */
module rtc_control_and_timing_pulse_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_ctrl_pkg::*;
  localparam int PW = 20;
  localparam int RW = 40;
  logic       clk, rst_n, xt, sel_n, pg, mc, hc, roe;
  logic [3:0] rdat;
  wire  [3:0] addr, hdat, dout, bus;
  wire        rd_n, wr_n, drv, oe_n, tp_val, tp_oe_n, h24, rreq, tp, sstep;
  int         mismatches = 0;
  int         compares = 0;
  int         rq = 0;
  int         st = 0;
  int         n;

  // Data pins resolved from both drivers; released pins show inverted data
  assign bus = drv ? hdat : (!oe_n ? dout : ~hdat);
  assign tp  = tp_oe_n ? 1'b1 : tp_val;

  rtc_host_model host (.clk_in(clk), .bus_in(bus), .oe_n_in(oe_n), .addr_out(addr),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .dat_out(hdat), .drv_out(drv));

  rtc_ctrl_top #(.PULSE_CYCLES(PW), .ROUND_CYCLES(RW)) dut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .XT_CLK_IN(xt), .ADDR_IN(addr),
    .ALE_IN(1'b1), .RD_N_IN(rd_n), .WR_N_IN(wr_n), .BUS_SELECT_N_IN(sel_n),
    .POWER_GOOD_SELECT_IN(pg), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n),
    .MIN_CARRY_IN(mc), .HOUR_CARRY_IN(hc), .SEC_STEP_OUT(sstep), .ROUND_REQ_OUT(rreq),
    .HOUR_24_MODE_OUT(h24), .TIMING_PULSE_OUT(tp_val), .TIMING_PULSE_OE_N_OUT(tp_oe_n));

  // System clock and a time base offset from its edges
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    xt = 1'b0;
    #3;
    forever #20 xt = ~xt;
  end

  // Rounding start pulses
  always @(posedge clk) if (rreq === 1'b1) rq <= rq + 1;
  // Seconds steps; a whole second of base ticks never passes in this run
  always @(posedge clk) if (sstep !== 1'b0) st <= st + 1;

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, w, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [3:0] e, input string w);
    host.rd(a, rdat, roe);
    chk(roe, 1'b0, w);
    chk(rdat, e, w);
  endtask

  // One-cycle carry from the minute or hour counter
  task automatic evt(input bit h);
    cyc(1);
    hc = h;
    mc = !h;
    cyc(1);
    hc = 1'b0;
    mc = 1'b0;
  endtask

  task automatic width(output int k);
    k = 0;
    for (int i = 0; i < 4000 && tp !== 1'b0; i++) cyc(1);
    while (tp === 1'b0 && k < 100) begin
      cyc(1);
      k++;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    sel_n = 1'b0;
    pg    = 1'b1;
    mc    = 1'b0;
    hc    = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    rdc(ADDR_HOLD, 4'h0, "hold reset");
    rdc(ADDR_PULSE, RST_PULSE_CTL, "pulse reset");
    rdc(ADDR_MODE, RST_MODE_CTL, "mode reset");
    host.wr(ADDR_MODE, 4'h4);
    chk(h24, 1'b1, "24h on");
    rdc(ADDR_MODE, 4'h4, "mode readback");
    host.wr(ADDR_MODE, 4'h0);
    chk(h24, 1'b0, "12h on");
    // Interrupt mode on minute carries
    host.wr(ADDR_PULSE, 4'ha);
    host.wr(ADDR_HOLD, 4'h0);
    host.wr(4'h0, 4'h9);
    chk(tp, 1'b1, "counter write");
    evt(0);
    cyc(1);
    chk(tp, 1'b0, "interrupt low");
    rdc(ADDR_HOLD, 4'h4, "flag set");
    evt(0);
    cyc(PW + 5);
    chk(tp, 1'b0, "still pending");
    host.wr(ADDR_HOLD, 4'h4);
    chk(tp, 1'b0, "write one keeps");
    host.wr(ADDR_HOLD, 4'h0);
    chk(tp, 1'b1, "cleared");
    rdc(ADDR_HOLD, 4'h0, "flag clear");
    // Seconds period ignores minute and hour carries
    host.wr(ADDR_PULSE, 4'h6);
    host.wr(ADDR_HOLD, 4'h0);
    evt(0);
    evt(1);
    cyc(2);
    chk(tp, 1'b1, "other digit ignored");
    // Masked output stays released
    host.wr(ADDR_PULSE, 4'hb);
    evt(0);
    cyc(2);
    chk(tp, 1'b1, "masked");
    // Standard mode on hour carries
    host.wr(ADDR_PULSE, 4'hc);
    host.wr(ADDR_HOLD, 4'h0);
    evt(1);
    width(n);
    chk(n, PW, "std width");
    evt(1);
    evt(1);
    cyc(2);
    host.wr(ADDR_HOLD, 4'h0);
    chk(tp, 1'b1, "early clear");
    evt(1);
    host.wr(ADDR_MODE, 4'h2);
    cyc(PW * 3);
    chk(tp, 1'b0, "stop freezes");
    host.wr(ADDR_MODE, 4'h0);
    cyc(PW);
    chk(tp, 1'b1, "run resumes");
    // Sixty-fourth second period from the time base
    host.wr(ADDR_PULSE, 4'h0);
    host.wr(ADDR_HOLD, 4'h0);
    width(n);
    chk(n, PW, "64 Hz width");
    n = 0;
    while (tp === 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    chk(n, 2560 - PW, "64 Hz gap");
    // Divider clear stops the sub-second events
    host.wr(ADDR_MODE, 4'h1);
    cyc(PW);
    n = 0;
    repeat (3000) begin
      cyc(1);
      if (tp === 1'b0) n++;
    end
    chk(n, 0, "divider held");
    sel_n = 1'b1;
    cyc(4);
    sel_n = 1'b0;
    rdc(ADDR_MODE, 4'h0, "clear forced off");
    width(n);
    chk(n, PW, "divider runs");
    // Freeze bit and the power-good select
    host.wr(ADDR_PULSE, 4'h1);
    host.wr(ADDR_HOLD, 4'h0);
    host.wr(ADDR_HOLD, 4'h5);
    rdc(ADDR_HOLD, 4'h1, "hold set");
    pg = 1'b0;
    cyc(4);
    pg = 1'b1;
    cyc(4);
    rdc(ADDR_HOLD, 4'h0, "hold forced off");
    // Half-minute rounding clears itself
    host.wr(ADDR_HOLD, 4'hc);
    cyc(1);
    chk(rq, 1, "round request");
    rdc(ADDR_HOLD, 4'ha, "rounding busy");
    cyc(RW);
    rdc(ADDR_HOLD, 4'h0, "round done");
    chk(st, 0, "no seconds step");
    report_and_stop;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    mismatches++;
    report_and_stop;
  end
endmodule // rtc_control_and_timing_pulse_tb_top
